// *** hdl/tps_sequencer.sv ***
// Notes on behaviour
// - An all-zero overshoot pattern disables protection so the normal drive applies through each overshoot sequence.
// - The two-bit level field sets the drive for set pattern bits: driver rail, modulation rail, or stop.
// - The 14-bit pattern is applied lsb first, bit 0 in the first cycle after a falling modulation edge.
// - From the fifteenth cycle after an edge the normal driver settings apply again.
// - An undershoot sequence with its own pattern and level runs after each rising modulation edge.
// - Both sequences may run together with wave shaping, independent of the legacy regulated setting.
`timescale 1ns/1ps
`default_nettype none

module tps_sequencer
    import tps_pkg::*;
#(
    parameter int PATTERN_LEN = TPS_PATTERN_LEN
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // modulation state from the encoder, high while modulated
    input wire logic modulated,
    // overshoot settings
    input wire logic [PATTERN_LEN-1:0] over_transition_drive_pattern,
    input wire logic [1:0] over_transition_drive_level_select,
    // undershoot settings
    input wire logic [PATTERN_LEN-1:0] under_transition_drive_pattern,
    input wire logic [1:0] under_transition_drive_level_select,
    // legacy setting, accepted but not consulted
    input wire logic legacy_regulated_modulation_select,
    // drive command to the output stage
    output tps_pkg::tps_drive_e drive_cmd,
    output logic override_active,
    output logic [TPS_CNT_W-1:0] pattern_index
);
    import tps_pkg::*;

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    logic mod_prev;

    // ----------------------------------------
    // sequence state and counters
    // ----------------------------------------
    tps_state_e state;
    tps_state_e next_state;
    logic [TPS_CNT_W-1:0] cnt;
    logic [TPS_CNT_W-1:0] next_cnt;
    tps_drive_e next_drive;

    // history resets low, so a high level at release counts as a rising edge
    wire fall_edge = mod_prev & ~modulated;
    wire rise_edge = ~mod_prev & modulated;
    wire last_bit = (cnt == TPS_CNT_LAST);

    // legacy select deliberately ignored: shaping needs no legacy mode
    wire unused_legacy = legacy_regulated_modulation_select;

    // ----------------------------------------
    // sequencing decode
    // ----------------------------------------
    wire running = (state != TPS_ST_IDLE);
    wire seq_done = running & last_bit;
    wire [TPS_CNT_W-1:0] cnt_step = cnt + 4'h1;

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    // index restarts at zero on every edge, even in mid-sequence
    always_comb
    begin
        next_state = state;
        next_cnt = cnt_step;
        if (fall_edge)
        begin
            next_state = TPS_ST_OVER;
            next_cnt = TPS_CNT_RESET;
        end
        else if (rise_edge)
        begin
            next_state = TPS_ST_UNDER;
            next_cnt = TPS_CNT_RESET;
        end
        else if (seq_done)
        begin
            next_state = TPS_ST_IDLE;
            next_cnt = TPS_CNT_RESET;
        end
        else if (!running)
        begin
            next_cnt = TPS_CNT_RESET;
        end
    end

    // ----------------------------------------
    // drive selection
    // ----------------------------------------
    wire over_sel = (next_state == TPS_ST_OVER);
    wire under_sel = (next_state == TPS_ST_UNDER);
    wire [PATTERN_LEN-1:0] sel_pattern = over_sel ? over_transition_drive_pattern
        : under_transition_drive_pattern;
    wire [1:0] sel_level = over_sel ? over_transition_drive_level_select
        : under_transition_drive_level_select;
    // settings are read live, so a change mid-sequence acts from the next cycle
    logic [PATTERN_LEN-1:0] bit_hit;
    genvar gi;
    generate
        for (gi = 0; gi < PATTERN_LEN; gi++)
        begin : g_bit_hit
            assign bit_hit[gi] = (next_cnt == TPS_CNT_W'(gi)) & sel_pattern[gi];
        end
    endgenerate

    // zero pattern leaves every bit clear, so normal drive throughout
    wire sel_bit = (over_sel | under_sel) & (|bit_hit);

    always_comb
    begin
        next_drive = TPS_DRV_NORMAL;
        if (sel_bit)
        begin
            unique case (tps_level_e'(sel_level))
                TPS_LVL_DRIVER_RAIL: next_drive = TPS_DRV_DRIVER_RAIL;
                TPS_LVL_MOD_RAIL: next_drive = TPS_DRV_MOD_RAIL;
                TPS_LVL_STOP: next_drive = TPS_DRV_STOP;
                // reserved code falls back to normal drive
                default: next_drive = TPS_DRV_NORMAL;
            endcase
        end
    end

    // ----------------------------------------
    // registers: edge history
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mod_prev <= 1'b0;
        end
        else
        begin
            mod_prev <= modulated;
        end
    end

    // ----------------------------------------
    // registers: sequence state
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= TPS_ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt <= TPS_CNT_RESET;
        end
        else
        begin
            cnt <= next_cnt;
        end
    end

    // ----------------------------------------
    // registers: outputs
    // ----------------------------------------
    // outputs come straight from flops so the stage sees no decode glitches
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            drive_cmd <= TPS_DRV_NORMAL;
        end
        else
        begin
            drive_cmd <= next_drive;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            override_active <= 1'b0;
        end
        else
        begin
            override_active <= sel_bit;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pattern_index <= TPS_CNT_RESET;
        end
        else
        begin
            pattern_index <= next_cnt;
        end
    end

endmodule : tps_sequencer

`default_nettype wire

// *** hdl/tps_pkg.sv ***
package tps_pkg;

    // ----------------------------------------
    // pattern geometry
    // ----------------------------------------
    localparam int TPS_PATTERN_LEN = 14;
    localparam int TPS_CNT_W = 4;
    localparam logic [TPS_CNT_W-1:0] TPS_CNT_LAST = 4'hD;
    localparam logic [TPS_CNT_W-1:0] TPS_CNT_RESET = 4'h0;

    // ----------------------------------------
    // drive levels
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        TPS_LVL_DRIVER_RAIL = 2'b00,
        TPS_LVL_MOD_RAIL = 2'b01,
        TPS_LVL_STOP = 2'b10,
        TPS_LVL_RESERVED = 2'b11
    } tps_level_e;

    // driver command presented to the output stage
    typedef enum logic [1:0]
    {
        TPS_DRV_NORMAL = 2'b00,
        TPS_DRV_DRIVER_RAIL = 2'b01,
        TPS_DRV_MOD_RAIL = 2'b10,
        TPS_DRV_STOP = 2'b11
    } tps_drive_e;

    // ----------------------------------------
    // sequencer states
    // ----------------------------------------
    typedef enum logic [1:0]
    {
        TPS_ST_IDLE = 2'b00,
        TPS_ST_OVER = 2'b01,
        TPS_ST_UNDER = 2'b10
    } tps_state_e;

endpackage : tps_pkg

// *** testbench/tps_drive_stage_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tps_drive_stage_model import tps_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire tps_pkg::tps_drive_e drive_cmd,
    output logic [7:0] ovr_cycles
);
    // counts cycles where the stage leaves its normal drive
    always_ff @(posedge clk)
        if (!rst_n) ovr_cycles <= 8'h00;
        else if (drive_cmd != TPS_DRV_NORMAL) ovr_cycles <= ovr_cycles + 8'h01;
endmodule : tps_drive_stage_model
`default_nettype wire

// *** testbench/tps_sequencer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module tps_sequencer_assertions import tps_pkg::*; #(parameter int PATTERN_LEN = 14) (
    input wire logic clk, rst_n, modulated, override_active,
    input wire logic [PATTERN_LEN-1:0] over_transition_drive_pattern,
    input wire logic [PATTERN_LEN-1:0] under_transition_drive_pattern,
    input wire logic [1:0] over_transition_drive_level_select,
    input wire logic [1:0] under_transition_drive_level_select,
    input wire tps_pkg::tps_drive_e drive_cmd,
    input wire logic [3:0] pattern_index
);
    wire logic m = modulated;
    wire logic o = override_active;
    wire logic [3:0] i = pattern_index;
    wire logic [PATTERN_LEN-1:0] op = over_transition_drive_pattern;
    wire logic [PATTERN_LEN-1:0] up = under_transition_drive_pattern;
    wire logic [1:0] ol = over_transition_drive_level_select;
    wire logic [1:0] ul = under_transition_drive_level_select;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // direction of the running sequence is the level held one cycle back
    AST_OVS: assert property ($fell(m) |=> i == 4'h0 && o == op[0]) else $error("bad start");
    AST_UNS: assert property ($rose(m) |=> i == 4'h0 && o == up[0]) else $error("bad start");
    AST_STEP: assert property (i != 4'h0 && i < 4'hD && !$changed(m) |=> i == $past(i) + 4'h1)
        else $error("bad step");
    AST_END: assert property (i == 4'hD && !$changed(m) |=> drive_cmd == TPS_DRV_NORMAL && i == 4'h0)
        else $error("no end");
    AST_BIT: assert property (o |-> ($past(m) ? up[i] : op[i])) else $error("bad bit");
    AST_LVL: assert property (o |-> drive_cmd == ($past(m) ? ul : ol) + 2'h1)
        else $error("bad level");
    AST_ZERO: assert property (!$past(m) && op == '0 |-> !o) else $error("not idle");
    cover property ($fell(m) ##1 o);
    cover property ($rose(m) ##1 o);
    cover property (i == 4'hD);
endmodule : tps_sequencer_assertions
`default_nettype wire

// *** testbench/tb_tps_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_tps_sequencer;
    import tps_pkg::*;
    logic clk = '0, rst_n = '0, modulated = '0, legacy_regulated_modulation_select = '0;
    logic [13:0] over_transition_drive_pattern = '0, under_transition_drive_pattern = '0;
    logic [1:0] over_transition_drive_level_select = '0, under_transition_drive_level_select = '0;
    tps_drive_e drive_cmd;
    logic override_active;
    logic [3:0] pattern_index;
    logic [7:0] ovr_cycles;
    int fail_count = 0, cmp_count = 0, cyc = 0;
    tps_sequencer dut_u (
        .clk(clk), .rst_n(rst_n), .modulated(modulated),
        .over_transition_drive_pattern(over_transition_drive_pattern),
        .over_transition_drive_level_select(over_transition_drive_level_select),
        .under_transition_drive_pattern(under_transition_drive_pattern),
        .under_transition_drive_level_select(under_transition_drive_level_select),
        .legacy_regulated_modulation_select(legacy_regulated_modulation_select),
        .drive_cmd(drive_cmd), .override_active(override_active), .pattern_index(pattern_index)
    );
    tps_drive_stage_model drv_u (
        .clk(clk), .rst_n(rst_n), .drive_cmd(drive_cmd), .ovr_cycles(ovr_cycles)
    );
    task chk(input string n, input logic [7:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task walk(input string n);
        logic [13:0] p;
        logic [1:0] l;
        p = modulated ? under_transition_drive_pattern : over_transition_drive_pattern;
        l = modulated ? under_transition_drive_level_select : over_transition_drive_level_select;
        for (int k = 0; k < 15; k++)
        begin
            @(posedge clk) #1;
            chk("drive", drive_cmd, (k < 14 && p[k] && l != 2'h3) ? l + 2'h1 : 2'h0);
            chk("index", pattern_index, (k < 14) ? 8'(k) : 8'h00);
            chk("override", override_active, (k < 14 && p[k]) ? 8'h01 : 8'h00);
        end
        $display("test %s done", n);
    endtask : walk
    task t_under;
        under_transition_drive_pattern = 14'h01C7;
        under_transition_drive_level_select = 2'h1;
        legacy_regulated_modulation_select = 1'h1;
        modulated = 1'h1;
        walk("under");
        chk("count", ovr_cycles, 8'h06);
    endtask : t_under
    task t_levels;
        over_transition_drive_pattern = 14'h2A5B;
        for (int l = 0; l < 4; l++)
        begin
            over_transition_drive_level_select = 2'(l);
            modulated = 1'h0;
            walk("over");
            modulated = 1'h1;
            walk("under_back");
        end
    endtask : t_levels
    task t_zero;
        over_transition_drive_pattern = '0;
        modulated = 1'h0;
        walk("zero");
        modulated = 1'h1;
        walk("zero_back");
    endtask : t_zero
    task t_restart;
        over_transition_drive_pattern = 14'h3FFF;
        over_transition_drive_level_select = 2'h2;
        modulated = 1'h0;
        repeat (6) @(posedge clk);
        #1 modulated = 1'h1;
        walk("restart");
    endtask : t_restart
    task conclude;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 2000)
        begin
            fail_count++;
            conclude();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'h1;
        t_under();
        t_levels();
        t_zero();
        t_restart();
        conclude();
    end
endmodule : tb_tps_sequencer
bind tps_sequencer tps_sequencer_assertions #(.PATTERN_LEN(PATTERN_LEN)) chk_u (
    .clk(clk), .rst_n(rst_n), .modulated(modulated), .override_active(override_active),
    .over_transition_drive_pattern(over_transition_drive_pattern),
    .under_transition_drive_pattern(under_transition_drive_pattern),
    .over_transition_drive_level_select(over_transition_drive_level_select),
    .under_transition_drive_level_select(under_transition_drive_level_select),
    .drive_cmd(drive_cmd), .pattern_index(pattern_index)
);
`default_nettype wire
